// ===== scc_map.svh
// constants of the spi slave command checker: frame layout, spi register
// addresses, field positions, wishbone offsets, reset values and timing.
// assumes it is included by scc_pkg and by the design modules.
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
// frame layout, lsb sent first
`define SCC_FRAME_BITS  5'h10
`define SCC_ADDR_LAST   5'h06
`define SCC_BITS_MAX    5'h1F
`define SCC_ALL_ZERO    16'h0000
`define SCC_ALL_ONE     16'hFFFF
// spi register addresses
`define SCC_A_MODE      7'h01
`define SCC_A_WD        7'h03
`define SCC_A_XCVR      7'h04
`define SCC_A_WAKE      7'h06
`define SCC_A_TIMER     7'h0C
`define SCC_A_DEV       7'h43
`define SCC_A_WSA       7'h46
`define SCC_A_WSB       7'h47
// mode_control fields
`define SCC_MC_REQ      7:6
`define SCC_MC_OTHER    5:0
`define SCC_MC_LS       5
`define SCC_REQ_NORMAL  2'h0
`define SCC_REQ_SLEEP   2'h1
`define SCC_REQ_STOP    2'h2
`define SCC_REQ_SOFT    2'h3
// wake_control and timer fields
`define SCC_WAKE_PIN_MEASURE     7
`define SCC_WK_PINS     6:0
`define SCC_WK_A_ONLY   7'h01
`define SCC_WK_B_ONLY   7'h02
`define SCC_TM_ON       3:0
`define SCC_TM_PER      7:4
// wishbone word offsets and fields
`define SCC_WB_STATUS   8'h00
`define SCC_WB_CTRL     8'h04
`define SCC_WB_LAST     8'h08
`define SCC_WB_REGS     8'h0C
`define SCC_CTRL_CLR    0
// reset values, synchroniser order {reset_out_n, select_low, sdi, sclk}
`define SCC_SYNC_RST    4'hC
// timing
`define SCC_CLK_NS      10
`define SCC_INT_NS      1000
`define SCC_INT_CYC     (`SCC_INT_NS / `SCC_CLK_NS)
`endif

// ===== scc_pkg.sv
// types shared by the spi slave command checker modules.
// assumes scc_map.svh sits in the include path.
`include "scc_map.svh"
package scc_pkg;
  // device modes, gray coded along init-normal-stop-sleep-restart
  typedef enum logic [2:0]
  {
    SCC_INIT    = 3'h0,
    SCC_NORMAL  = 3'h1,
    SCC_STOP    = 3'h3,
    SCC_SLEEP   = 3'h2,
    SCC_RESTART = 3'h6
  } scc_mode_e;

  // spi-visible control and status bytes
  typedef struct packed {
    logic [7:0] mode_ctrl;
    logic [7:0] watchdog_control;
    logic [7:0] xcvr_ctrl;
    logic [7:0] wake_ctrl;
    logic [7:0] timer_ctrl;
    logic [7:0] wake_stat_a;
    logic [7:0] wake_stat_b;
  } scc_regs_s;

  // outcome of checking one received frame
  typedef struct packed {
    scc_regs_s  regs;
    logic       fault;
    logic       clr_fault;
    logic       mode_chg;
    logic       stop_int;
    scc_mode_e  mode_nx;
  } scc_verdict_s;

  // synchroniser state
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } scc_sync_s;
endpackage

// ===== scc_sync.sv
// two flip-flop synchroniser for the spi pins and the reset output level.
// assumes inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_sync
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // pins in, synchronised levels out
  input  wire logic [3:0] async_i,
  output var  logic [3:0] sync_o
);
  scc_sync_s st;
  scc_sync_s next_st;

  // first stage feeds only the second
  always_comb
  begin
    next_st    = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st.s1 <= `SCC_SYNC_RST;
      st.s2 <= `SCC_SYNC_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_o = st.s2;
endmodule
`default_nettype wire

// ===== scc_cmd_check.sv
// checks one received frame against the mode state and the current
// register contents, and gives the verdict combinationally.
// assumes the caller applies the verdict only after select has risen.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_cmd_check
  import scc_pkg::*;
(
  // frame and context
  input  wire logic [15:0] cmd_i,
  input  wire scc_mode_e   mode_i,
  input  wire scc_regs_s   regs_i,
  // verdict
  output var  scc_verdict_s verdict_o
);
  logic [7:0] data;
  logic [1:0] req;
  logic [7:0] new_mc;
  logic       no_src;
  logic       pin_only;
  logic       ls_keep;

  // decode the frame and judge it
  always_comb
  begin
    data     = cmd_i[15:8];
    req      = data[`SCC_MC_REQ];
    new_mc   = data;
    new_mc[`SCC_MC_LS] = data[`SCC_MC_LS] | regs_i.mode_ctrl[`SCC_MC_LS];
    ls_keep  = regs_i.mode_ctrl[`SCC_MC_LS] & ~data[`SCC_MC_LS];
    no_src   = (regs_i.xcvr_ctrl == 8'h00) && (regs_i.wake_ctrl == 8'h00);
    pin_only = regs_i.wake_ctrl[`SCC_WAKE_PIN_MEASURE]
               && (regs_i.wake_ctrl[`SCC_WK_PINS] == `SCC_WK_A_ONLY
               || regs_i.wake_ctrl[`SCC_WK_PINS] == `SCC_WK_B_ONLY);
    verdict_o         = '0;
    verdict_o.regs    = regs_i;
    verdict_o.mode_nx = mode_i;
    if (cmd_i == `SCC_ALL_ZERO || cmd_i == `SCC_ALL_ONE)
    begin
      verdict_o.fault = 1'b1;
    end
    else if (mode_i != SCC_RESTART && cmd_i[7])
    begin
      case (cmd_i[6:0])
        `SCC_A_MODE:
        begin
          verdict_o.mode_chg = 1'b1;
          if (mode_i == SCC_STOP)
          begin
            case (req)
              `SCC_REQ_NORMAL:
              begin
                verdict_o.mode_nx = SCC_NORMAL;
                verdict_o.fault = data[`SCC_MC_OTHER]
                                  != regs_i.mode_ctrl[`SCC_MC_OTHER];
                verdict_o.regs.mode_ctrl[`SCC_MC_REQ] = req;
              end
              `SCC_REQ_SOFT:  verdict_o.mode_nx = SCC_RESTART;
              `SCC_REQ_SLEEP:
              begin
                verdict_o.fault   = 1'b1;
                verdict_o.mode_nx = SCC_RESTART;
              end
              default:
              begin
                verdict_o.mode_chg = 1'b0;
                verdict_o.fault = data[`SCC_MC_OTHER]
                                  != regs_i.mode_ctrl[`SCC_MC_OTHER];
              end
            endcase
          end
          else if (mode_i == SCC_INIT
                   && (req == `SCC_REQ_SLEEP || req == `SCC_REQ_STOP))
          begin
            verdict_o.fault   = 1'b1;
            verdict_o.mode_nx = SCC_NORMAL;
            verdict_o.regs.mode_ctrl = {`SCC_REQ_NORMAL,
                                        new_mc[`SCC_MC_OTHER]};
          end
          else
          begin
            verdict_o.regs.mode_ctrl = new_mc;
            verdict_o.fault = ls_keep;
            case (req)
              `SCC_REQ_NORMAL: verdict_o.mode_nx = SCC_NORMAL;
              `SCC_REQ_STOP:
              begin
                verdict_o.mode_nx  = SCC_STOP;
                verdict_o.stop_int = |{regs_i.wake_stat_a,
                                       regs_i.wake_stat_b};
              end
              `SCC_REQ_SLEEP:
              begin
                if (no_src || pin_only)
                begin
                  verdict_o.fault   = 1'b1;
                  verdict_o.mode_nx = SCC_RESTART;
                end
                else
                begin
                  verdict_o.mode_nx = SCC_SLEEP;
                end
              end
              default: verdict_o.mode_nx = SCC_RESTART;
            endcase
          end
        end
        `SCC_A_WD:
        begin
          if (^data)
            verdict_o.fault = 1'b1;
          else if (mode_i == SCC_STOP && data != regs_i.watchdog_control)
            verdict_o.fault = 1'b1;
          else
            verdict_o.regs.watchdog_control = data;
        end
        `SCC_A_XCVR, `SCC_A_WAKE, `SCC_A_TIMER:
        begin
          if (mode_i == SCC_STOP)
            verdict_o.fault = 1'b1;
          else if (cmd_i[6:0] == `SCC_A_TIMER
                   && data[`SCC_TM_ON] >= data[`SCC_TM_PER])
            verdict_o.fault = 1'b1;
          else if (cmd_i[6:0] == `SCC_A_TIMER)
            verdict_o.regs.timer_ctrl = data;
          else if (cmd_i[6:0] == `SCC_A_WAKE)
            verdict_o.regs.wake_ctrl = data;
          else
            verdict_o.regs.xcvr_ctrl = data;
        end
        `SCC_A_DEV: verdict_o.clr_fault = 1'b1;
        `SCC_A_WSA: verdict_o.regs.wake_stat_a = 8'h00;
        `SCC_A_WSB: verdict_o.regs.wake_stat_b = 8'h00;
        default: ; // unused address, no fault
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== scc_spi_slave.sv
// spi slave with command checking: shifts 16-bit frames, judges each frame
// when select rises, reports frame errors on serial_out, wishbone status.
// assumes pins are asynchronous; wake events come from logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module scc_spi_slave
  import scc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // spi pins
  input  wire logic        sclk_i,
  input  wire logic        select_low_i,
  input  wire logic        serial_in_i,
  output var  logic        serial_out_o,
  output var  logic        serial_out_oe_o,
  // system side
  input  wire logic        reset_out_n_i,
  input  wire logic [7:0]  wake_evt_a_i,
  input  wire logic [7:0]  wake_evt_b_i,
  output var  logic        interrupt_out_o,
  output var  logic        restart_o
);
  typedef struct packed {
    scc_mode_e   mode;
    scc_regs_s   regs;
    logic        fault;
    logic        err_flag;
    logic        sclk_q;
    logic        csn_q;
    logic        ro_q;
    logic        in_frame;
    logic [4:0]  bits;
    logic [15:0] rx;
    logic [15:0] tx;
    logic        clk_err;
    logic        ro_hit;
    logic        done;
    logic [15:0] last_cmd;
    logic [7:0]  int_cnt;
    logic        int_o;
    logic        restart;
    logic        so;
    logic        so_oe;
    logic        ack;
    logic [31:0] rdat;
  } scc_state_s;

  scc_state_s   st;
  scc_state_s   next_st;
  scc_verdict_s verdict;
  logic [3:0]   pins_s;
  logic         sclk_s;
  logic         sdi_s;
  logic         csn_s;
  logic         ro_s;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         csn_fall;
  logic         csn_rise;
  logic         frame_bad;
  logic         wb_req;
  logic         wb_clr;
  logic         clr_any;
  logic [15:0]  rx_n;

  // read byte of an spi register, used for serial_out only; wishbone reads its own fields
  function automatic logic [7:0] scc_read(input logic [6:0] addr,
                                          input scc_regs_s r,
                                          input logic f);
    case (addr)
      `SCC_A_MODE:  scc_read = r.mode_ctrl;
      `SCC_A_WD:    scc_read = r.watchdog_control;
      `SCC_A_XCVR:  scc_read = r.xcvr_ctrl;
      `SCC_A_WAKE:  scc_read = r.wake_ctrl;
      `SCC_A_TIMER: scc_read = r.timer_ctrl;
      `SCC_A_DEV:   scc_read = {7'h00, f};
      `SCC_A_WSA:   scc_read = r.wake_stat_a;
      `SCC_A_WSB:   scc_read = r.wake_stat_b;
      default:      scc_read = 8'h00;
    endcase
  endfunction

  // pins pass two flip-flops before any use
  scc_sync u_sync
  (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({reset_out_n_i, select_low_i, serial_in_i, sclk_i}),
    .sync_o    (pins_s)
  );

  // frame judge
  scc_cmd_check u_check
  (
    .cmd_i     (st.rx),
    .mode_i    (st.mode),
    .regs_i    (st.regs),
    .verdict_o (verdict)
  );

  // edges of the synchronised pins
  assign sclk_s    = pins_s[0];
  assign sdi_s     = pins_s[1];
  assign csn_s     = pins_s[2];
  assign ro_s      = pins_s[3];
  assign sclk_rise = sclk_s & ~st.sclk_q;
  assign sclk_fall = ~sclk_s & st.sclk_q;
  assign csn_fall  = ~csn_s & st.csn_q & ~st.in_frame;
  assign csn_rise  = csn_s & ~st.csn_q & st.in_frame;
  assign rx_n      = {sdi_s, st.rx[15:1]};
  assign frame_bad = (st.bits != 5'h00 && st.bits != `SCC_FRAME_BITS)
                     | st.clk_err | sclk_s | st.ro_hit | ~ro_s;

  // bus request and fault clear
  assign wb_req  = wb_cyc_i & wb_stb_i & ~st.ack;
  assign wb_clr  = wb_req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == `SCC_WB_CTRL) & wb_dat_i[`SCC_CTRL_CLR];
  assign clr_any = wb_clr | (st.done & verdict.clr_fault);

  // next state of the whole block
  always_comb
  begin
    next_st        = st;
    next_st.sclk_q = sclk_s;
    next_st.csn_q  = csn_s;
    next_st.ro_q   = ro_s;
    next_st.done   = 1'b0;
    if (csn_fall)
    begin
      // frame opens, error of the last frame goes out first
      next_st.in_frame = 1'b1;
      next_st.bits     = 5'h00;
      next_st.clk_err  = sclk_s;
      next_st.ro_hit   = ~ro_s;
      next_st.tx       = {8'h00, st.mode, st.fault,
                          |{st.regs.wake_stat_a, st.regs.wake_stat_b},
                          2'h0, st.err_flag};
    end
    else if (st.in_frame)
    begin
      next_st.ro_hit = st.ro_hit | ~ro_s;
      if (csn_rise)
      begin
        next_st.in_frame = 1'b0;
        next_st.err_flag = frame_bad;
        next_st.done = ~frame_bad
                       & (st.bits == `SCC_FRAME_BITS);
      end
      else if (sclk_rise)
      begin
        next_st.tx = {1'b0, st.tx[15:1]};
      end
      else if (sclk_fall)
      begin
        next_st.rx = rx_n;
        if (st.bits != `SCC_BITS_MAX)
          next_st.bits = st.bits + 5'h01;
        if (st.bits == `SCC_ADDR_LAST)
          next_st.tx[8:1] = scc_read(rx_n[15:9], st.regs,
                                     st.fault);
      end
    end
    // apply a validated frame
    if (st.done)
    begin
      next_st.regs     = verdict.regs;
      next_st.last_cmd = st.rx;
      if (verdict.mode_chg)
        next_st.mode = verdict.mode_nx;
    end
    // mode exits driven by the system
    if (st.mode == SCC_SLEEP && |{wake_evt_a_i, wake_evt_b_i})
      next_st.mode = SCC_RESTART;
    if (st.mode == SCC_RESTART && ro_s && ~st.ro_q)
      next_st.mode = SCC_INIT;
    // wake events win over a read-and-clear
    next_st.regs.wake_stat_a = next_st.regs.wake_stat_a | wake_evt_a_i;
    next_st.regs.wake_stat_b = next_st.regs.wake_stat_b | wake_evt_b_i;
    // sticky fault, a new fault wins over the clear
    next_st.fault = (st.fault & ~clr_any)
                    | (st.done & verdict.fault);
    // interrupt pulse on stop entry with pending wake status
    if (st.int_cnt != 8'h00)
      next_st.int_cnt = st.int_cnt - 8'h01;
    if (st.done && verdict.stop_int)
      next_st.int_cnt = 8'(`SCC_INT_CYC);
    next_st.int_o   = next_st.int_cnt != 8'h00;
    next_st.restart = next_st.mode == SCC_RESTART;
    // serial_out held high while reset output is low
    next_st.so    = ~ro_s | next_st.tx[0];
    next_st.so_oe = next_st.in_frame;
    // wishbone slave, one wait state
    next_st.ack = wb_req;
    if (wb_req)
    begin
      case (wb_adr_i)
        `SCC_WB_STATUS: next_st.rdat = {26'h000_0000, ro_s, st.mode,
                                        st.err_flag, st.fault};
        `SCC_WB_LAST:   next_st.rdat = {16'h0000, st.last_cmd};
        `SCC_WB_REGS:   next_st.rdat = {st.regs.timer_ctrl,
                                        st.regs.wake_ctrl,
                                        st.regs.xcvr_ctrl,
                                        st.regs.mode_ctrl};
        default:        next_st.rdat = 32'h0000_0000;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st       <= '0;
      st.csn_q <= 1'b1;
      st.ro_q  <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o        = st.rdat;
  assign wb_ack_o        = st.ack;
  assign serial_out_o    = st.so;
  assign serial_out_oe_o = st.so_oe;
  assign interrupt_out_o = st.int_o;
  assign restart_o       = st.restart;

  // checks
  a_stuck_frame: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && (st.rx == `SCC_ALL_ZERO || st.rx == `SCC_ALL_ONE)
    |=> st.fault)
    else $error("stuck frame did not raise the fault");
  a_bad_count: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    csn_rise && st.bits != 5'h00 && st.bits != `SCC_FRAME_BITS
    |=> st.err_flag && !st.done ##1 $stable(st.regs.mode_ctrl))
    else $error("bad clock count not flagged or not discarded");
  a_release_out: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    csn_rise |=> !serial_out_oe_o && !st.in_frame)
    else $error("serial_out not released at select rise");
  a_reset_high: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.in_frame && !ro_s && !csn_rise |=> serial_out_o ##0 st.ro_hit)
    else $error("serial_out not high during reset output low");
  a_fault_sticky: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.fault && !clr_any |=> st.fault)
    else $error("fault dropped without a clear");
  a_stop_sleep: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode == SCC_STOP && st.rx[7:0] == {1'b1, `SCC_A_MODE}
    && st.rx[15:14] == `SCC_REQ_SLEEP && st.rx != `SCC_ALL_ONE
    |=> st.mode == SCC_RESTART && st.fault)
    else $error("stop to sleep did not fault into restart");
  a_init_normal: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode == SCC_INIT && st.rx[7:0] == {1'b1, `SCC_A_MODE}
    && st.rx[15:14] == `SCC_REQ_STOP
    |=> st.mode == SCC_NORMAL && st.fault)
    else $error("stop from init did not fault into normal");
  a_wd_parity: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode != SCC_RESTART && (^st.rx[15:8])
    && st.rx[7:0] == {1'b1, `SCC_A_WD}
    |=> st.fault && $stable(st.regs.watchdog_control))
    else $error("odd watchdog byte was not rejected");
  a_load_share: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.regs.mode_ctrl[`SCC_MC_LS] |=> st.regs.mode_ctrl[`SCC_MC_LS])
    else $error("load share bit was cleared");
  a_no_mid_write: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.in_frame ##1 st.in_frame |-> $stable(st.regs.mode_ctrl))
    else $error("register changed while shifting");
  a_stop_int: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && verdict.stop_int |=> ##1 interrupt_out_o [*8])
    else $error("stop entry with wake status gave no interrupt");
  a_sleep_nosrc: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode == SCC_NORMAL && st.rx[7:0] == {1'b1, `SCC_A_MODE}
    && st.rx[15:14] == `SCC_REQ_SLEEP && st.regs.xcvr_ctrl == 8'h00
    && st.regs.wake_ctrl == 8'h00 |=> st.mode == SCC_RESTART && st.fault)
    else $error("sleep without wake source did not fault");
  a_sleep_pin: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode == SCC_NORMAL && st.rx[7:0] == {1'b1, `SCC_A_MODE}
    && st.rx[15:14] == `SCC_REQ_SLEEP && st.regs.wake_ctrl[`SCC_WAKE_PIN_MEASURE]
    && (st.regs.wake_ctrl[`SCC_WK_PINS] == `SCC_WK_A_ONLY
    || st.regs.wake_ctrl[`SCC_WK_PINS] == `SCC_WK_B_ONLY)
    |=> st.mode == SCC_RESTART && st.fault)
    else $error("sleep on one measured pin did not fault");
  a_stop_normal: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.done && st.mode == SCC_STOP && st.rx[7:0] == {1'b1, `SCC_A_MODE}
    && st.rx[15:14] == `SCC_REQ_NORMAL
    |=> st.mode == SCC_NORMAL
    && $stable(st.regs.mode_ctrl[`SCC_MC_OTHER]))
    else $error("stop to normal changed other mode fields");
  a_shift_in: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.in_frame && sclk_fall && !csn_rise |=> st.rx[15] == $past(sdi_s))
    else $error("serial_in not shifted on falling serial clock");
  a_shift_out: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    st.in_frame && sclk_rise && !csn_rise && ro_s
    |=> serial_out_o == $past(st.tx[1]))
    else $error("serial_out not advanced after rising serial clock");
  a_open_frame: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    csn_fall && ro_s |=> st.in_frame && serial_out_oe_o
    && serial_out_o == $past(st.err_flag))
    else $error("frame error bit not shown at frame start");
endmodule
`default_nettype wire

// ===== scc_spi_master.sv
// spi master model that drives the device pins, lsb first.
// assumes the bench clock at 100 MHz; serial clock period of 9 cycles.
`timescale 1ns/1ps
`default_nettype none
module scc_spi_master
(
  // bench clock
  input  wire logic clk_i,
  // spi pins
  output var  logic sclk_o,
  output var  logic select_low_o,
  output var  logic serial_in_o,
  input  wire logic serial_out_i
);
  // idle pins: clock low, select high
  initial
  begin
    sclk_o = 1'b0;
    select_low_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // one frame of n clocks; rx holds the bit seen before each rise
  task automatic xfer(input int n, input logic [15:0] tx,
                      output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk_i) select_low_o <= 1'b0;
    for (int i = 0; i < ((n > 0) ? n : 1); i++)
    begin
      @(posedge clk_i) serial_in_o <= tx[i];
      repeat (4) @(posedge clk_i);
      rx[i] = serial_out_i;
      if (i < n)
      begin
        sclk_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sclk_o <= 1'b0;
      end
    end
    repeat (4) @(posedge clk_i);
    serial_in_o <= ~serial_in_o; // released line shows no stale bit
    select_low_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== testbench.sv
// self-checking bench of the spi slave with wishbone status access.
// assumes scc_pkg, scc_spi_slave and scc_spi_master are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "scc_map.svh"
module testbench
  import scc_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        ro_n = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [7:0]  ea = 8'h00;
  logic [7:0]  eb = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] q;
  logic [31:0] seed = 32'h0000_0030;
  logic [15:0] rx;
  logic [7:0]  tm = 8'h00;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          cnt = 0;
  wire  [31:0] wb_dat;
  wire         ack;
  wire         so;
  wire         oe;
  wire         irq;
  wire         rst_o;
  wire         sclk;
  wire         sel_n;
  wire         serial_in;
  wire         sdo_w = oe ? so : 1'bz;
  // clock and timeout
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cnt <= cnt + 1;
    if (cnt == 60000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  // device and master model
  scc_spi_slave u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
    .sclk_i(sclk), .select_low_i(sel_n), .serial_in_i(serial_in),
    .serial_out_o(so), .serial_out_oe_o(oe), .reset_out_n_i(ro_n),
    .wake_evt_a_i(ea), .wake_evt_b_i(eb), .interrupt_out_o(irq),
    .restart_o(rst_o));
  scc_spi_master u_mst (.clk_i(clk_i), .sclk_o(sclk),
    .select_low_o(sel_n), .serial_in_o(serial_in), .serial_out_i(sdo_w));
  // expectation and stimulus helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic tm_bad(input logic [7:0] v);
    return v[3:0] >= v[7:4];
  endfunction
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack !== 1'b1);
    q = wb_dat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic stat(input scc_mode_e m, input logic f);
    wb(1'b0, `SCC_WB_STATUS, 32'h0000_0000);
    chk("mode", {29'h0, q[4:2]}, {29'h0, m});
    chk("fault", {31'h0, q[0]}, {31'h0, f});
  endtask
  task automatic clr();
    wb(1'b1, `SCC_WB_CTRL, 32'h0000_0001);
  endtask
  task automatic frame(input logic [15:0] w);
    u_mst.xfer(16, w, rx);
    chk("oe", {31'h0, oe}, 32'h0000_0000);
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    stat(SCC_INIT, 1'b0);
    frame(16'h8081);
    stat(SCC_NORMAL, 1'b1);
    clr();
    stat(SCC_NORMAL, 1'b0);
    frame(16'h0000);
    stat(SCC_NORMAL, 1'b1);
    clr();
    frame(16'hFFFF);
    stat(SCC_NORMAL, 1'b1);
    clr();
    $display("test mode and stuck done");
    for (int k = 0; k < 8; k++)
    begin
      seed = xs(seed);
      frame({seed[7:0], 8'h90});
      stat(SCC_NORMAL, 1'b0);
      frame({seed[15:8], 8'h8C});
      stat(SCC_NORMAL, tm_bad(seed[15:8]));
      tm = tm_bad(seed[15:8]) ? tm : seed[15:8];
      wb(1'b0, `SCC_WB_REGS, 32'h0000_0000);
      chk("timer", {24'h0, q[31:24]}, {24'h0, tm});
      clr();
      frame({seed[23:16], 8'h83});
      stat(SCC_NORMAL, ^seed[23:16]);
      clr();
    end
    $display("test random fields done");
    u_mst.xfer(8, 16'h0000, rx);
    u_mst.xfer(0, 16'h0000, rx);
    chk("err", {31'h0, rx[0]}, 32'h0000_0001);
    stat(SCC_NORMAL, 1'b0);
    u_mst.xfer(0, 16'h0000, rx);
    chk("err", {31'h0, rx[0]}, 32'h0000_0000);
    $display("test clock count done");
    seed = xs(seed);
    @(posedge clk_i) {ea, eb} <= {seed[7:0] | 8'h01, seed[15:8]};
    @(posedge clk_i) {ea, eb} <= 16'h0000;
    frame(16'h0046);
    chk("wake", {16'h0, rx[15:8]}, {24'h0, seed[7:0] | 8'h01});
    chk("word", {24'h0, rx[7:0]}, {24'h0, 3'h1, 5'h08});
    frame(16'h8081);
    chk("irq", {31'h0, irq}, 32'h0000_0001);
    stat(SCC_STOP, 1'b0);
    frame(16'h5A84);
    stat(SCC_STOP, 1'b1);
    wb(1'b0, `SCC_WB_REGS, 32'h0000_0000);
    chk("xcvr", {24'h0, q[15:8]}, 32'h0000_0000);
    clr();
    frame(16'h4081);
    chk("restart", {31'h0, rst_o}, 32'h0000_0001);
    stat(SCC_RESTART, 1'b1);
    $display("test stop mode done");
    @(posedge clk_i) ro_n <= 1'b0;
    u_mst.xfer(16, 16'h1234, rx);
    chk("sdo", {16'h0, rx}, 32'h0000_FFFF);
    @(posedge clk_i) ro_n <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("restart", {31'h0, rst_o}, 32'h0000_0000);
    u_mst.xfer(0, 16'h0000, rx);
    chk("err", {31'h0, rx[0]}, 32'h0000_0001);
    $display("test reset output done");
    clr();
    frame(16'h2081);
    frame(16'h8081);
    stat(SCC_STOP, 1'b1);
    wb(1'b0, `SCC_WB_REGS, 32'h0000_0000);
    chk("ls", {24'h0, q[7:0]}, {24'h0, `SCC_REQ_STOP, 6'h20});
    clr();
    frame(16'h0081);
    stat(SCC_NORMAL, 1'b1);
    wb(1'b0, `SCC_WB_REGS, 32'h0000_0000);
    chk("other", {24'h0, q[7:0]}, 32'h0000_0020);
    clr();
    frame(16'h6081);
    stat(SCC_RESTART, 1'b1);
    wb(1'b0, `SCC_WB_REGS, 32'h0000_0000);
    chk("kept", {24'h0, q[7:0]}, {24'h0, `SCC_REQ_SLEEP, 6'h20});
    clr();
    @(posedge clk_i) ro_n <= 1'b0;
    repeat (4) @(posedge clk_i);
    ro_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    frame(16'h2081);
    frame(16'h8186);
    stat(SCC_NORMAL, 1'b0);
    frame(16'h6081);
    stat(SCC_RESTART, 1'b1);
    $display("test mode rules done");
    final_report();
  end
endmodule
`default_nettype wire
